// file: core/reset_seq_consts.svh
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH

// Clock period in ns (50 MHz)
`define CLK_PERIOD_NS 20
// Power-up timer nominal time in ms
`define PWRUP_TIME_MS 72
// Power-up timer cycles, rounded down
`define PWRUP_CYCLES ((`PWRUP_TIME_MS * 1000000) / `CLK_PERIOD_NS)
// Oscillator start-up timer, in oscillator periods
`define OST_PERIODS 1024
// Glitch filter minimum low time in ns
`define GLITCH_TIME_NS 2000
// Glitch filter cycles, rounded up
`define GLITCH_CYCLES ((`GLITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Status bit values after power-on
`define POR_STATUS_VAL 1'h0
`define TO_PD_POR_VAL 1'h1

`endif

// file: core/reset_seq_pkg.sv
package reset_seq_pkg;
  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POWER_ON,
    CAUSE_EXT_RUN,
    CAUSE_EXT_SLEEP,
    CAUSE_WDT_RUN,
    CAUSE_WDT_WAKE,
    CAUSE_BROWNOUT
  } reset_cause_t;
endpackage

// file: core/reset_source_and_timeout_sequencer.sv
`include "reset_seq_consts.svh"

// Contract
// - Distinguish power-on, pin run, pin sleep, watchdog run, watchdog wake, brown-out.
// - Undefined-after-power-on registers are never reset by any cause.
// - Other registers reset on power-on, brown-out, pin resets and watchdog run reset.
// - Watchdog wake from sleep resumes execution without register reset.
// - Time-out and power-down bits take a pattern per cause; power-on and brown-out share one, pin resets keep the bits.
// - External reset pin is filtered; short low pulses are ignored.
// - Power-up timer starts after power-on pulse; oscillator timer follows it.
// - Start-up delay depends on oscillator choice and power-up timer enable.
// - RC oscillator with power-up timer disabled gives no start-up delay.
// - Timers run regardless of pin; execution starts on pin release after.
// - Power-on bit reads zero after power-on; software sets it to one.
// - Power-on forces time-out and power-down bits to one.
module reset_source_and_timeout_sequencer
  import reset_seq_pkg::*;
#(
  parameter int PWRUP_COUNT = `PWRUP_CYCLES,
  parameter int OST_COUNT = `OST_PERIODS,
  parameter int GLITCH_COUNT = `GLITCH_CYCLES
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic power_on_detect_in,
  input wire logic external_reset_n_in,
  input wire logic watchdog_timeout_source_in,
  input wire logic brownout_detect_in,
  input wire logic sleep_active_in,
  input wire logic osc_tick_in,
  input wire logic resistor_capacitor_oscillator_in,
  input wire logic power_up_timer_enable_in,
  input wire logic sleep_cmd_in,
  input wire logic clrwdt_cmd_in,
  input wire logic power_on_status_set_in,
  output logic core_reset_out,
  output logic reg_reset_out,
  output logic wake_out,
  output logic timeout_status_out,
  output logic power_down_status_out,
  output logic power_on_status_out,
  output logic brownout_status_out,
  output reset_cause_t reset_cause_out
);

  initial begin
    if (PWRUP_COUNT < 1 || OST_COUNT < 1 || GLITCH_COUNT < 1) begin
      $error("Counts must be at least one");
    end
  end

  localparam int PW = $clog2(PWRUP_COUNT + 1);
  localparam int OW = $clog2(OST_COUNT + 1);
  localparam int GW = $clog2(GLITCH_COUNT + 1);

  // ==========================================================
  // Reset release and input synchronisers
  logic rst_s1_reg, rst_n;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_reg <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_s1_reg <= 1'h1;
      rst_n <= rst_s1_reg;
    end
  end

  localparam int NS = 5;
  logic [NS-1:0] raw_in, s1_reg, s2_reg;
  assign raw_in = {power_on_detect_in, external_reset_n_in, watchdog_timeout_source_in,
                   brownout_detect_in, osc_tick_in};
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 5'h08;
      s2_reg <= 5'h08;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end
  logic por_s, pin_s, wdt_s, bod_s, tick_s;
  assign {por_s, pin_s, wdt_s, bod_s, tick_s} = s2_reg;

  // ==========================================================
  // Pin glitch filter
  logic [GW-1:0] glitch_cnt_reg;
  logic pin_filt_reg;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      glitch_cnt_reg <= '0;
      pin_filt_reg <= 1'h1;
    end else if (pin_s) begin
      glitch_cnt_reg <= '0;
      pin_filt_reg <= 1'h1;
    end else if (glitch_cnt_reg == GW'(GLITCH_COUNT - 1)) begin
      pin_filt_reg <= 1'h0;
    end else begin
      glitch_cnt_reg <= glitch_cnt_reg + GW'(1);
    end
  end
  logic pin_filt_d_reg;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_filt_d_reg <= 1'h1;
    end else begin
      pin_filt_d_reg <= pin_filt_reg;
    end
  end
  logic pin_fall;
  assign pin_fall = pin_filt_d_reg && !pin_filt_reg;

  // ==========================================================
  // Event edges
  logic wdt_d_reg, bod_d_reg, por_d_reg, tick_d_reg;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      wdt_d_reg <= 1'h0;
      bod_d_reg <= 1'h0;
      por_d_reg <= 1'h0;
      tick_d_reg <= 1'h0;
    end else begin
      wdt_d_reg <= wdt_s;
      bod_d_reg <= bod_s;
      por_d_reg <= por_s;
      tick_d_reg <= tick_s;
    end
  end
  logic wdt_rise, bod_rise, tick_rise, por_end;
  assign wdt_rise = wdt_s && !wdt_d_reg;
  assign bod_rise = bod_s && !bod_d_reg;
  assign tick_rise = tick_s && !tick_d_reg;
  assign por_end = por_d_reg && !por_s;

  // ==========================================================
  // Cause classification
  function automatic reset_cause_t classify(input logic por, input logic brownout_detect,
      input logic pinf, input logic wdt, input logic slp);
    reset_cause_t c;
    c = CAUSE_NONE;
    if (por) begin
      c = CAUSE_POWER_ON;
    end else if (brownout_detect) begin
      c = CAUSE_BROWNOUT;
    end else if (pinf) begin
      c = slp ? CAUSE_EXT_SLEEP : CAUSE_EXT_RUN;
    end else if (wdt) begin
      c = slp ? CAUSE_WDT_WAKE : CAUSE_WDT_RUN;
    end
    return c;
  endfunction

  reset_cause_t cause_now;
  assign cause_now = classify(por_s && !por_d_reg, bod_rise, pin_fall, wdt_rise,
                              sleep_active_in);

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause_out <= CAUSE_POWER_ON;
    end else if (cause_now != CAUSE_NONE) begin
      reset_cause_out <= cause_now;
    end
  end

  // ==========================================================
  // Start-up sequencer
  typedef enum logic [2:0] {
    ST_POR, ST_POWER_UP_TIMER, ST_OST, ST_WAIT_PIN, ST_RUN
  } seq_state_t;
  seq_state_t state_reg;
  logic [PW-1:0] power_up_timer_cnt_reg;
  logic [OW-1:0] ost_cnt_reg;
  logic full_reset;
  assign full_reset = (cause_now == CAUSE_POWER_ON) || (cause_now == CAUSE_BROWNOUT);

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_POR;
      power_up_timer_cnt_reg <= '0;
      ost_cnt_reg <= '0;
    end else if (full_reset || por_s) begin
      state_reg <= ST_POR;
      power_up_timer_cnt_reg <= '0;
      ost_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_POR: begin
          if (!por_s) begin
            if (power_up_timer_enable_in) begin
              state_reg <= ST_POWER_UP_TIMER;
            end else if (resistor_capacitor_oscillator_in) begin
              state_reg <= ST_WAIT_PIN;
            end else begin
              state_reg <= ST_OST;
            end
          end
        end
        ST_POWER_UP_TIMER: begin
          if (power_up_timer_cnt_reg == PW'(PWRUP_COUNT - 1)) begin
            state_reg <= resistor_capacitor_oscillator_in ? ST_WAIT_PIN : ST_OST;
          end else begin
            power_up_timer_cnt_reg <= power_up_timer_cnt_reg + PW'(1);
          end
        end
        ST_OST: begin
          if (ost_cnt_reg == OW'(OST_COUNT)) begin
            state_reg <= ST_WAIT_PIN;
          end else if (tick_rise) begin
            ost_cnt_reg <= ost_cnt_reg + OW'(1);
          end
        end
        ST_WAIT_PIN: begin
          if (pin_filt_reg) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!pin_filt_reg || cause_now == CAUSE_WDT_RUN) begin
            state_reg <= ST_WAIT_PIN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Reset outputs
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_out <= 1'h1;
      reg_reset_out <= 1'h1;
      wake_out <= 1'h0;
    end else begin
      core_reset_out <= (state_reg != ST_RUN);
      // Bank left undefined is never driven by this strobe
      reg_reset_out <= full_reset || pin_fall ||
                       (cause_now == CAUSE_WDT_RUN) || (state_reg == ST_POR);
      wake_out <= (cause_now == CAUSE_WDT_WAKE);
    end
  end

  // ==========================================================
  // Status bits
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      timeout_status_out <= `TO_PD_POR_VAL;
      power_down_status_out <= `TO_PD_POR_VAL;
    end else begin
      unique case (cause_now)
        CAUSE_POWER_ON, CAUSE_BROWNOUT: begin
          timeout_status_out <= `TO_PD_POR_VAL;
          power_down_status_out <= `TO_PD_POR_VAL;
        end
        CAUSE_WDT_RUN: begin
          timeout_status_out <= 1'h0;
          power_down_status_out <= 1'h1;
        end
        CAUSE_WDT_WAKE: begin
          timeout_status_out <= 1'h0;
          power_down_status_out <= 1'h0;
        end
        CAUSE_EXT_RUN, CAUSE_EXT_SLEEP: begin
          // Pin reset keeps time-out and power-down bits
        end
        CAUSE_NONE: begin
          if (sleep_cmd_in) begin
            timeout_status_out <= 1'h1;
            power_down_status_out <= 1'h0;
          end else if (clrwdt_cmd_in) begin
            timeout_status_out <= 1'h1;
            power_down_status_out <= 1'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      power_on_status_out <= `POR_STATUS_VAL;
      brownout_status_out <= 1'h0;
    end else begin
      if (cause_now == CAUSE_POWER_ON) begin
        power_on_status_out <= `POR_STATUS_VAL;
      end else if (power_on_status_set_in) begin
        power_on_status_out <= 1'h1;
      end
      if (cause_now == CAUSE_BROWNOUT) begin
        brownout_status_out <= 1'h0;
      end else if (power_on_status_set_in) begin
        brownout_status_out <= 1'h1;
      end
    end
  end

endmodule // reset_source_and_timeout_sequencer

// file: test/reset_seq_asserts.sv
// ==========================================
// Port checker
module reset_seq_checker
  import reset_seq_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic power_on_detect_in,
  input wire logic external_reset_n_in,
  input wire logic watchdog_timeout_source_in,
  input wire logic sleep_active_in,
  input wire logic power_up_timer_enable_in,
  input wire logic sleep_cmd_in,
  input wire logic clrwdt_cmd_in,
  input wire logic core_reset_out,
  input wire logic reg_reset_out,
  input wire logic wake_out,
  input wire logic timeout_status_out,
  input wire logic power_down_status_out,
  input wire logic power_on_status_out,
  input wire reset_cause_t reset_cause_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  por_bits_a: assert property ($rose(power_on_detect_in) |-> ##[3:8]
    (timeout_status_out && power_down_status_out && !power_on_status_out)) else $error("por bits");
  pin_hold_a: assert property ((!external_reset_n_in) [*8] |=> core_reset_out)
    else $error("pin hold");
  release_pin_a: assert property ($fell(core_reset_out) |->
    ($past(external_reset_n_in, 3) && external_reset_n_in)) else $error("release");
  wake_cause_a: assert property ($rose(wake_out) |-> ##[0:1]
    reset_cause_out == CAUSE_WDT_WAKE) else $error("wake cause");
  wake_regs_a: assert property (wake_out |-> !reg_reset_out) else $error("wake regs");
  wake_bits_a: assert property ($rose(wake_out) |-> ##[0:1]
    (!timeout_status_out && !power_down_status_out)) else $error("wake bits");
  sleep_bits_a: assert property (sleep_cmd_in |-> ##[1:3]
    (timeout_status_out && !power_down_status_out)) else $error("sleep bits");
  clrwdt_bits_a: assert property (clrwdt_cmd_in |-> ##[1:3]
    (timeout_status_out && power_down_status_out)) else $error("clear bits");
  por_hold_a: assert property ($rose(power_on_detect_in) && power_up_timer_enable_in
    |-> ##5 core_reset_out [*8]) else $error("por hold");
  wdt_run_a: assert property ($rose(watchdog_timeout_source_in) && !sleep_active_in
    |-> ##[3:8] reg_reset_out) else $error("wdt run");
  cover property ($rose(wake_out));
  cover property ($fell(core_reset_out));
  cover property ($rose(reg_reset_out));
endmodule // reset_seq_checker

bind reset_source_and_timeout_sequencer reset_seq_checker u_chk (.*);

// file: test/supply_pin_model.sv
// ==========================================
// Supply monitor, reset pin and oscillator
module supply_pin_model (
  input wire logic clock_in,
  input wire logic por_go_in,
  input wire logic pin_go_in,
  input wire logic [7:0] pin_len_in,
  output logic power_on_detect_out,
  output logic external_reset_n_out,
  output logic osc_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int por_cnt = 0;
  int pin_cnt = 0;
  int osc_cnt = 0;
  initial begin
    power_on_detect_out = 1'h0;
    external_reset_n_out = 1'h1;
    osc_tick_out = 1'h0;
  end
  always @(posedge clock_in) begin
    if (por_go_in) por_cnt = 4;
    if (pin_go_in) pin_cnt = int'(pin_len_in);
    #2;
    power_on_detect_out = por_cnt > 0;
    external_reset_n_out = pin_cnt == 0;
    osc_cnt = (osc_cnt + 1) % 3;
    if (osc_cnt == 0) osc_tick_out = ~osc_tick_out;
    if (por_cnt > 0) por_cnt--;
    if (pin_cnt > 0) pin_cnt--;
  end
endmodule // supply_pin_model

// file: test/tb_reset_source_and_timeout_sequencer.sv
module tb_reset_source_and_timeout_sequencer;
  import reset_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, rstn_in = 0, watchdog_timeout_source_in = 0, brownout_detect_in = 0;
  logic sleep_active_in = 0, resistor_capacitor_oscillator_in = 0, power_up_timer_enable_in = 1;
  logic sleep_cmd_in = 0, clrwdt_cmd_in = 0, power_on_status_set_in = 0, por_go = 0, pin_go = 0;
  logic power_on_detect_in, external_reset_n_in, osc_tick_in, saw_reg = 0, saw_wake = 0;
  logic [7:0] pin_len = 8'h00;
  logic core_reset_out, reg_reset_out, wake_out, timeout_status_out, power_down_status_out;
  logic power_on_status_out, brownout_status_out;
  reset_cause_t reset_cause_out;
  int fails = 0, cmp_count = 0, n;
  initial forever #10 clock_in = ~clock_in;
  reset_source_and_timeout_sequencer #(.PWRUP_COUNT(20), .OST_COUNT(4), .GLITCH_COUNT(3))
    u_dut (.*);
  supply_pin_model u_model (.clock_in(clock_in), .por_go_in(por_go), .pin_go_in(pin_go),
    .pin_len_in(pin_len), .power_on_detect_out(power_on_detect_in),
    .external_reset_n_out(external_reset_n_in), .osc_tick_out(osc_tick_in));
  always @(posedge clock_in) begin
    if (reg_reset_out === 1'h1) saw_reg <= 1'h1;
    if (wake_out === 1'h1) saw_wake <= 1'h1;
  end
  // ==========================================
  // Helpers
  task step(input int k);
    repeat (k) @(posedge clock_in);
    #2;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task end_sim;
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wait_core(input logic lvl);
    n = 0;
    while (core_reset_out !== lvl) begin
      step(1);
      n++;
      if (n > 300) begin
        fails++;
        end_sim();
      end
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  // ==========================================
  // Scenarios
  task t_por(input logic en, input logic rc, input int lo, input int hi);
    power_up_timer_enable_in = en;
    resistor_capacitor_oscillator_in = rc;
    pulse(por_go);
    wait_core(1);
    wait_core(0);
    chk(8'(n >= lo && n < hi), 8'h01);
    chk({timeout_status_out, power_down_status_out, power_on_status_out}, 8'h06);
    chk(reset_cause_out, CAUSE_POWER_ON);
    pulse(power_on_status_set_in);
    step(3);
    chk(power_on_status_out, 8'h01);
  endtask
  task t_pin_run;
    pin_len = 8'h02;
    pulse(pin_go);
    step(12);
    chk(core_reset_out, 8'h00);
    pin_len = 8'h0A;
    saw_reg = 0;
    pulse(pin_go);
    wait_core(1);
    wait_core(0);
    chk(reset_cause_out, CAUSE_EXT_RUN);
    chk({saw_reg, timeout_status_out, power_on_status_out}, 8'h07);
  endtask
  task t_sleep;
    sleep_active_in = 1;
    pulse(sleep_cmd_in);
    step(3);
    chk({timeout_status_out, power_down_status_out}, 8'h02);
    saw_reg = 0;
    pulse(watchdog_timeout_source_in);
    step(8);
    chk({saw_wake, saw_reg}, 8'h02);
    chk(reset_cause_out, CAUSE_WDT_WAKE);
    chk({timeout_status_out, power_down_status_out}, 8'h00);
    pulse(sleep_cmd_in);
    pulse(pin_go);
    wait_core(1);
    sleep_active_in = 0;
    wait_core(0);
    chk(reset_cause_out, CAUSE_EXT_SLEEP);
    chk({saw_reg, timeout_status_out, power_down_status_out}, 8'h06);
  endtask
  task t_wdt_bod;
    pulse(clrwdt_cmd_in);
    step(3);
    chk({timeout_status_out, power_down_status_out}, 8'h03);
    saw_reg = 0;
    pulse(watchdog_timeout_source_in);
    step(10);
    wait_core(0);
    chk(reset_cause_out, CAUSE_WDT_RUN);
    chk({saw_reg, timeout_status_out, power_down_status_out}, 8'h05);
    pulse(brownout_detect_in);
    step(8);
    chk({brownout_status_out, reset_cause_out}, {5'h00, CAUSE_BROWNOUT});
    wait_core(0);
    chk({timeout_status_out, power_down_status_out}, 8'h03);
    pulse(power_on_status_set_in);
    step(3);
    chk(brownout_status_out, 8'h01);
  endtask
  task t_pin_through_por;
    power_up_timer_enable_in = 1;
    resistor_capacitor_oscillator_in = 0;
    pin_len = 8'h50;
    pulse(pin_go);
    pulse(por_go);
    step(75);
    chk(core_reset_out, 8'h01);
    wait_core(0);
    chk(8'(n < 12), 8'h01);
  endtask
  initial begin
    step(6);
    rstn_in = 1;
    step(4);
    t_por(1, 0, 44, 90);
    t_por(0, 0, 24, 60);
    t_por(1, 1, 20, 44);
    t_por(0, 1, 0, 10);
    t_pin_run();
    t_sleep();
    t_wdt_bod();
    t_pin_through_por();
    end_sim();
  end
endmodule // tb_reset_source_and_timeout_sequencer
